// ---- hw/light_i2c_pkg.sv ----
// Constants, codes and state encodings for the light sensor I2C target
package light_i2c_pkg;

	// System clock rate and the SCL-low bus timeout
	localparam int CLK_SYS_KHZ  = 50000;
	localparam int TIMEOUT_MS   = 28;
	localparam int TIMEOUT_CYC  = TIMEOUT_MS * CLK_SYS_KHZ;

	// Target addresses by address-select strap, and the fixed variant
	localparam logic [6:0] ADDR_GND   = 7'h44;
	localparam logic [6:0] ADDR_VDD   = 7'h45;
	localparam logic [6:0] ADDR_SDA   = 7'h46;
	localparam logic [6:0] ADDR_SCL   = 7'h45;
	localparam logic [6:0] ADDR_FIXED = 7'h45;

	// Strap encodings of the address-select input
	localparam logic [1:0] SEL_GND = 2'h0;
	localparam logic [1:0] SEL_VDD = 2'h1;
	localparam logic [1:0] SEL_SDA = 2'h2;
	localparam logic [1:0] SEL_SCL = 2'h3;

	// Special bus addresses and command bytes
	localparam logic [7:0] GCALL_BYTE   = 8'h00;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam logic [6:0] ADDR_ALERT   = 7'h0C;
	localparam logic [4:0] HS_CODE      = 5'h01;

	// Bit count of one byte, pointer value after reset
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// Link-side protocol states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_ADDR   = 4'b0001,
		ST_PTR    = 4'b0010,
		ST_WDATA  = 4'b0011,
		ST_GCALL  = 4'b0100,
		ST_ACK    = 4'b0101,
		ST_TX     = 4'b0110,
		ST_MACK   = 4'b0111,
		ST_IGNORE = 4'b1000
	} link_state_t;

endpackage : light_i2c_pkg

// ---- hw/light_i2c_target.sv ----
// I2C/SMBus target front end of an ambient light sensor
//
// Contract
// - Bus rates up to 100 kHz, 400 kHz and 2.6 MHz high-speed.
// - Shift address on SCL rise; last bit is direction; ack on ninth clock.
// - SCL held low for the timeout resets the bus state machine.
// - Strap selects address: gnd 1000100, vdd 1000101, sda 1000110, scl 1000101.
// - Strap sampled at every transfer; system settles it beforehand.
// - Variant without strap answers only the fixed address.
// - Every byte moves most significant bit first.
// - First byte after write address loads the register pointer.
// - Next two bytes, high first, write the pointed register; each acked.
// - Reads use the last written pointer; it persists across transfers.
// - Read sends upper byte then lower; controller may nack or stop.
// - High-speed code is not acked but switches filters to high speed.
// - A stop ends high-speed mode.
// - With burst enabled, pointer advances after each two-byte read whose low byte is acked.
// - Stop restores the read pointer to the written pointer.
// - General call followed by reset byte is acked and resets registers.
// - Alert response answered only in latched window mode.
// - With interrupt active, send own address, arbitrate; winning clears interrupt.
// - Last bit of alert address byte carries the high-threshold flag.
// - Alert response leaves both threshold flags unchanged.
module light_i2c_target
	import light_i2c_pkg::*;
#(
	parameter bit PIN_SELECT     = 1'b1,
	parameter int TIMEOUT_CYCLES = light_i2c_pkg::TIMEOUT_CYC
) (
	// System clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Link sampling clock
	input  wire logic        clk_link,
	// Bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic [1:0]  addr_sel,
	output logic             hs_mode,
	// Register file side, system clock
	output logic             wr_valid,
	output logic [7:0]       wr_addr,
	output logic [15:0]      wr_data,
	output logic [7:0]       rd_addr,
	input  wire logic [15:0] rd_data,
	output logic             gc_reset,
	// Alert and mode controls, system clock
	input  wire logic        burst_en,
	input  wire logic        latch_mode,
	input  wire logic        int_active,
	input  wire logic        flag_high,
	output logic             alert_clr
);

	// Link domain state
	typedef struct packed {
		logic        scl_m, scl_s, scl_p;
		logic        sda_m, sda_s, sda_p;
		logic [1:0]  sel_m, sel_s;
		logic        burst_m, burst_s;
		logic        latch_m, latch_s;
		logic        intr_m, intr_s;
		logic        flag_m, flag_s;
		logic        tout_m, tout_s, tout_p;
		link_state_t st;
		link_state_t nxt;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [6:0]  own;
		logic [7:0]  ptr_w;
		logic [7:0]  ptr_rd;
		logic [15:0] rd_word;
		logic [7:0]  tx;
		logic        lo;
		logic        alert;
		logic [7:0]  wr_hi;
		logic [15:0] wr_word;
		logic [7:0]  wr_ptr;
		logic        wr_tgl;
		logic [7:0]  rq_addr;
		logic        rq_tgl;
		logic        gc_tgl;
		logic        ac_tgl;
		logic        hs;
		logic        sda_o;
		logic        oe_n;
	} link_t;

	// System domain state
	typedef struct packed {
		logic        scl_m, scl_s;
		logic [31:0] tcnt;
		logic        tout_tgl;
		logic        wr_m, wr_s, wr_p;
		logic        rq_m, rq_s, rq_p;
		logic        gc_m, gc_s, gc_p;
		logic        ac_m, ac_s, ac_p;
		logic        rq_wait;
		logic [15:0] hold;
		logic        wr_valid;
		logic [7:0]  wr_addr;
		logic [15:0] wr_data;
		logic [7:0]  rd_addr;
		logic        gc_reset;
		logic        alert_clr;
	} sys_t;

	localparam logic [31:0] TOUT_LIM = 32'(TIMEOUT_CYCLES);

	link_t l_r, l_nxt;
	sys_t  s_r, s_nxt;

	// Own address from the strap, or the fixed one
	function automatic logic [6:0] own_addr(input logic [1:0] sel);
		logic [6:0] a;
		a = ADDR_FIXED;
		if (PIN_SELECT) begin
			case (sel)
				SEL_GND: a = ADDR_GND;
				SEL_VDD: a = ADDR_VDD;
				SEL_SDA: a = ADDR_SDA;
				SEL_SCL: a = ADDR_SCL;
				default: a = ADDR_FIXED;
			endcase
		end
		return a;
	endfunction

	// Link protocol engine, next state
	always_comb begin
		logic       rise, fall, start, stop, ack;
		logic [7:0] txb;
		l_nxt = l_r;
		rise  = l_r.scl_s & ~l_r.scl_p;
		fall  = ~l_r.scl_s & l_r.scl_p;
		start = l_r.scl_s & l_r.scl_p & l_r.sda_p & ~l_r.sda_s;
		stop  = l_r.scl_s & l_r.scl_p & ~l_r.sda_p & l_r.sda_s;
		ack   = 1'b0;
		txb   = l_r.tx;
		// Pin and cross-domain synchronisers
		l_nxt.scl_m   = scl_in;
		l_nxt.scl_s   = l_r.scl_m;
		l_nxt.scl_p   = l_r.scl_s;
		l_nxt.sda_m   = sda_in;
		l_nxt.sda_s   = l_r.sda_m;
		l_nxt.sda_p   = l_r.sda_s;
		l_nxt.sel_m   = addr_sel;
		l_nxt.sel_s   = l_r.sel_m;
		l_nxt.burst_m = burst_en;
		l_nxt.burst_s = l_r.burst_m;
		l_nxt.latch_m = latch_mode;
		l_nxt.latch_s = l_r.latch_m;
		l_nxt.intr_m  = int_active;
		l_nxt.intr_s  = l_r.intr_m;
		l_nxt.flag_m  = flag_high;
		l_nxt.flag_s  = l_r.flag_m;
		l_nxt.tout_m  = s_r.tout_tgl;
		l_nxt.tout_s  = l_r.tout_m;
		l_nxt.tout_p  = l_r.tout_s;
		l_nxt.sda_o   = 1'b0;
		if (l_r.tout_s != l_r.tout_p) begin
			// Bus timeout: back to idle, release the line
			l_nxt.st     = ST_IDLE;
			l_nxt.oe_n   = 1'b1;
			l_nxt.hs     = 1'b0;
			l_nxt.ptr_rd = l_r.ptr_w;
		end else if (stop) begin
			l_nxt.st     = ST_IDLE;
			l_nxt.oe_n   = 1'b1;
			l_nxt.hs     = 1'b0;
			l_nxt.ptr_rd = l_r.ptr_w;
		end else if (start) begin
			// Start or repeated start; strap read afresh
			l_nxt.st   = ST_ADDR;
			l_nxt.cnt  = 4'h0;
			l_nxt.oe_n = 1'b1;
			l_nxt.own  = own_addr(l_r.sel_s);
		end else begin
			case (l_r.st)
				ST_ADDR, ST_PTR, ST_WDATA, ST_GCALL: begin
					if (rise && l_r.cnt != BITS_BYTE) begin
						l_nxt.sh  = {l_r.sh[6:0], l_r.sda_s};
						l_nxt.cnt = l_r.cnt + 4'h1;
					end else if (fall && l_r.cnt == BITS_BYTE) begin
						l_nxt.nxt = ST_IGNORE;
						case (l_r.st)
							ST_ADDR: begin
								if (l_r.sh[7:1] == l_r.own) begin
									ack = 1'b1;
									l_nxt.alert = 1'b0;
									if (l_r.sh[0]) begin
										// Read: fetch the pointed word
										l_nxt.nxt     = ST_TX;
										l_nxt.lo      = 1'b0;
										l_nxt.rq_addr = l_r.ptr_rd;
										l_nxt.rq_tgl  = ~l_r.rq_tgl;
									end else begin
										l_nxt.nxt = ST_PTR;
									end
								end else if (l_r.sh == GCALL_BYTE) begin
									ack       = 1'b1;
									l_nxt.nxt = ST_GCALL;
								end else if (l_r.sh[7:3] == HS_CODE && !l_r.hs) begin
									l_nxt.hs = 1'b1;
								end else if (l_r.sh == {ADDR_ALERT, 1'b1} && l_r.latch_s
										&& l_r.intr_s) begin
									ack         = 1'b1;
									l_nxt.nxt   = ST_TX;
									l_nxt.alert = 1'b1;
								end
							end
							ST_PTR: begin
								ack          = 1'b1;
								l_nxt.ptr_w  = l_r.sh;
								l_nxt.ptr_rd = l_r.sh;
								l_nxt.lo     = 1'b0;
								l_nxt.nxt    = ST_WDATA;
							end
							ST_WDATA: begin
								ack = 1'b1;
								if (!l_r.lo) begin
									l_nxt.wr_hi = l_r.sh;
									l_nxt.lo    = 1'b1;
									l_nxt.nxt   = ST_WDATA;
								end else begin
									l_nxt.wr_word = {l_r.wr_hi, l_r.sh};
									l_nxt.wr_ptr  = l_r.ptr_w;
									l_nxt.wr_tgl  = ~l_r.wr_tgl;
								end
							end
							ST_GCALL: begin
								if (l_r.sh == GC_RESET_CMD) begin
									ack          = 1'b1;
									l_nxt.gc_tgl = ~l_r.gc_tgl;
									l_nxt.ptr_w  = PTR_RESET;
									l_nxt.ptr_rd = PTR_RESET;
								end
							end
							default: l_nxt.nxt = ST_IGNORE;
						endcase
						l_nxt.oe_n = ~ack;
						l_nxt.cnt  = 4'h0;
						l_nxt.st   = ack ? ST_ACK : ST_IGNORE;
					end
				end
				ST_ACK: begin
					// End of ack bit; start sending if a read follows
					if (fall) begin
						l_nxt.st   = l_r.nxt;
						l_nxt.cnt  = 4'h0;
						l_nxt.oe_n = 1'b1;
						if (l_r.nxt == ST_TX) begin
							if (l_r.alert) begin
								txb = {l_r.own, l_r.flag_s};
							end else begin
								l_nxt.rd_word = s_r.hold;
								txb           = s_r.hold[15:8];
							end
							l_nxt.tx   = txb;
							l_nxt.oe_n = txb[7];
						end
					end
				end
				ST_TX: begin
					if (rise) begin
						l_nxt.cnt = l_r.cnt + 4'h1;
						// Released a one but the line is low: lost
						if (l_r.alert && l_r.oe_n && !l_r.sda_s) begin
							l_nxt.st   = ST_IGNORE;
							l_nxt.oe_n = 1'b1;
						end
					end else if (fall) begin
						if (l_r.cnt == BITS_BYTE) begin
							l_nxt.oe_n = 1'b1;
							l_nxt.st   = ST_MACK;
							if (l_r.alert) begin
								l_nxt.ac_tgl = ~l_r.ac_tgl;
							end
						end else begin
							l_nxt.tx   = {l_r.tx[6:0], 1'b0};
							l_nxt.oe_n = l_r.tx[6];
						end
					end
				end
				ST_MACK: begin
					if (rise && (l_r.sda_s || l_r.alert)) begin
						l_nxt.st = ST_IGNORE;
					end else if (fall) begin
						l_nxt.st  = ST_TX;
						l_nxt.cnt = 4'h0;
						if (!l_r.lo) begin
							// Low byte; prefetch the word sent next
							l_nxt.lo      = 1'b1;
							txb           = l_r.rd_word[7:0];
							l_nxt.rq_addr = l_r.burst_s ? l_r.ptr_rd + 8'h01 : l_r.ptr_rd;
							l_nxt.rq_tgl  = ~l_r.rq_tgl;
						end else begin
							l_nxt.lo      = 1'b0;
							l_nxt.rd_word = s_r.hold;
							txb           = s_r.hold[15:8];
							if (l_r.burst_s) begin
								l_nxt.ptr_rd = l_r.ptr_rd + 8'h01;
							end
						end
						l_nxt.tx   = txb;
						l_nxt.oe_n = txb[7];
					end
				end
				ST_IDLE, ST_IGNORE: l_nxt.oe_n = 1'b1;
				default: begin
					l_nxt.st   = ST_IDLE;
					l_nxt.oe_n = 1'b1;
				end
			endcase
		end
	end

	// Link state register
	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			l_r <= '{st: ST_IDLE, nxt: ST_IDLE, oe_n: 1'b1, scl_m: 1'b1,
				scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
				sda_p: 1'b1, ptr_w: PTR_RESET, ptr_rd: PTR_RESET,
				rd_word: WORD_RESET, wr_word: WORD_RESET, default: '0};
		end else begin
			l_r <= l_nxt;
		end
	end

	// System side: timeout counter and event receivers
	always_comb begin
		s_nxt          = s_r;
		s_nxt.scl_m    = scl_in;
		s_nxt.scl_s    = s_r.scl_m;
		s_nxt.wr_m     = l_r.wr_tgl;
		s_nxt.wr_s     = s_r.wr_m;
		s_nxt.wr_p     = s_r.wr_s;
		s_nxt.rq_m     = l_r.rq_tgl;
		s_nxt.rq_s     = s_r.rq_m;
		s_nxt.rq_p     = s_r.rq_s;
		s_nxt.gc_m     = l_r.gc_tgl;
		s_nxt.gc_s     = s_r.gc_m;
		s_nxt.gc_p     = s_r.gc_s;
		s_nxt.ac_m     = l_r.ac_tgl;
		s_nxt.ac_s     = s_r.ac_m;
		s_nxt.ac_p     = s_r.ac_s;
		s_nxt.wr_valid = s_r.wr_s != s_r.wr_p;
		s_nxt.gc_reset = s_r.gc_s != s_r.gc_p;
		s_nxt.alert_clr = s_r.ac_s != s_r.ac_p;
		s_nxt.rq_wait  = s_r.rq_s != s_r.rq_p;
		// SCL low time; one toggle per stuck-low episode
		if (s_r.scl_s) begin
			s_nxt.tcnt = 32'h0;
		end else if (s_r.tcnt != TOUT_LIM) begin
			s_nxt.tcnt = s_r.tcnt + 32'h1;
			if (s_r.tcnt == TOUT_LIM - 32'h1) begin
				s_nxt.tout_tgl = ~s_r.tout_tgl;
			end
		end
		// Word fields are stable while their toggle travels
		if (s_r.wr_s != s_r.wr_p) begin
			s_nxt.wr_addr = l_r.wr_ptr;
			s_nxt.wr_data = l_r.wr_word;
		end
		if (s_r.rq_s != s_r.rq_p) begin
			s_nxt.rd_addr = l_r.rq_addr;
		end
		if (s_r.rq_wait) begin
			s_nxt.hold = rd_data;
		end
	end

	// System state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r <= '{scl_m: 1'b1, scl_s: 1'b1, rd_addr: PTR_RESET,
				hold: WORD_RESET, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign sda_out   = l_r.sda_o;
	assign sda_oe_n  = l_r.oe_n;
	assign hs_mode   = l_r.hs;
	assign wr_valid  = s_r.wr_valid;
	assign wr_addr   = s_r.wr_addr;
	assign wr_data   = s_r.wr_data;
	assign rd_addr   = s_r.rd_addr;
	assign gc_reset  = s_r.gc_reset;
	assign alert_clr = s_r.alert_clr;

endmodule // light_i2c_target

// ---- testbench/light_i2c_checker.sv ----
// Concurrent checks on the light sensor bus target ports
module light_i2c_checker #(
	parameter bit PIN_SELECT     = 1'b1,
	parameter int TIMEOUT_CYCLES = 200
) (
	// Clocks and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_link,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic hs_mode,
	// Pulses and alert controls
	input wire logic wr_valid,
	input wire logic gc_reset,
	input wire logic latch_mode,
	input wire logic int_active,
	input wire logic alert_clr
);
	timeunit 1ns;
	timeprecision 1ps;
	// Counts system cycles of SCL held low
	int low_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			low_r <= 0;
		else if (scl_in)
			low_r <= 0;
		else if (low_r < TIMEOUT_CYCLES + 50)
			low_r <= low_r + 1;
	end

	// Bus stop condition
	sequence s_stop;
		scl_in && $rose(sda_in);
	endsequence

	chk_stop_hs_off: assert property (@(posedge clk_link) disable iff (rst)
		s_stop |-> ##[1:8] !hs_mode) else $error("hs mode kept after stop");
	chk_hs_no_ack: assert property (@(posedge clk_link) disable iff (rst)
		$rose(hs_mode) |-> sda_oe_n [*8]) else $error("hs code acknowledged");
	chk_drive_scl_low: assert property (@(posedge clk_link) disable iff (rst)
		$fell(sda_oe_n) |-> !scl_in) else $error("sda drive began with scl high");
	chk_drive_stands: assert property (@(posedge clk_link) disable iff (rst)
		$fell(sda_oe_n) |-> !sda_oe_n [*8]) else $error("sda drive too short");
	chk_open_drain: assert property (@(posedge clk_link) disable iff (rst)
		sda_out == 1'b0) else $error("sda driven high");
	chk_wr_single: assert property (@(posedge clk_sys) disable iff (rst)
		wr_valid |=> !wr_valid) else $error("write pulse too long");
	chk_gc_single: assert property (@(posedge clk_sys) disable iff (rst)
		gc_reset |=> !gc_reset) else $error("reset pulse too long");
	chk_alert_cause: assert property (@(posedge clk_sys) disable iff (rst)
		alert_clr |-> latch_mode && int_active) else $error("alert clear unprompted");
	chk_timeout_idle: assert property (@(posedge clk_sys) disable iff (rst)
		low_r == TIMEOUT_CYCLES + 50 |-> sda_oe_n && !hs_mode)
		else $error("bus not idle after timeout");
endmodule : light_i2c_checker

bind light_i2c_target light_i2c_checker #(
	.PIN_SELECT(PIN_SELECT), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk_u (
	.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hs_mode(hs_mode),
	.wr_valid(wr_valid), .gc_reset(gc_reset), .latch_mode(latch_mode),
	.int_active(int_active), .alert_clr(alert_clr)
);

// ---- testbench/i2c_ctrl_model.sv ----
// Bus controller model driving SCL and SDA
module i2c_ctrl_model (
	// Pacing clock
	input  wire logic clk_sys,
	// Resolved data wire and driven lines
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_c
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_c = 1'b1;
	end
	// Wait n system cycles at falling edges
	task automatic hp(input int n = 40);
		repeat (n) @(negedge clk_sys);
	endtask
	// Start or repeated start
	task automatic start();
		sda_c = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_c = 1'b0;
		hp();
		scl = 1'b0;
		hp();
	endtask
	// Stop, bus released after
	task automatic stop();
		sda_c = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_c = 1'b1;
		hp();
	endtask
	// One bit, sampled mid-high
	task automatic bit1(input logic b, output logic r);
		sda_c = b;
		hp();
		scl = 1'b1;
		hp(20);
		r = sda_w;
		hp(20);
		scl = 1'b0;
		hp(8);
	endtask
	// Send a byte, high bit first
	task automatic wb(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit1(b[i], r);
		bit1(1'b1, r);
		ack = ~r;
	endtask
	// Read a byte; pull contests bits, ak acks it
	task automatic rb(input logic ak, input logic [7:0] pull, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit1(~pull[i], d[i]);
		bit1(~ak, r);
	endtask
endmodule : i2c_ctrl_model

// ---- testbench/light_i2c_target_bench.sv ----
// Testbench for the light sensor bus target
module light_i2c_target_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import light_i2c_pkg::*;
	logic        clk_sys = 1'b0;
	logic        clk_link = 1'b0;
	logic        rst = 1'b1;
	logic [1:0]  addr_sel = 2'h0;
	logic        burst_en = 1'b0;
	logic        latch_mode = 1'b0;
	logic        int_active = 1'b0;
	logic        flag_high = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic        sda_out, sda_oe_n, hs_mode, wr_valid, gc_reset, alert_clr, scl, sda_c, a;
	logic [7:0]  wr_addr, rd_addr, d;
	logic [15:0] wr_data;
	logic [23:0] w_seen;
	logic        fix_oe_n, fx_p;
	logic [6:0]  tbl [4] = '{7'h44, 7'h45, 7'h46, 7'h45};
	int          failures = 0, total_checks = 0, n_wr = 0, n_gc = 0, n_al = 0, n_fx = 0;
	wire         sda_w = sda_c & (sda_oe_n | sda_out);

	always #10 clk_sys = ~clk_sys;
	initial #7 forever #24 clk_link = ~clk_link;

	// Register file stand-in and pulse counters
	always @(negedge clk_sys) rd_data <= {rd_addr, ~rd_addr};
	// Sampled mid-cycle, away from the edge that launches the pulses
	always @(negedge clk_sys) begin
		if (wr_valid === 1'b1)
			w_seen <= {wr_addr, wr_data};
		n_wr <= n_wr + int'(wr_valid === 1'b1);
		n_gc <= n_gc + int'(gc_reset === 1'b1);
		n_al <= n_al + int'(alert_clr === 1'b1);
		fx_p <= fix_oe_n;
		n_fx <= n_fx + int'(fx_p === 1'b1 && fix_oe_n === 1'b0);
	end

	light_i2c_target #(.TIMEOUT_CYCLES(200)) dut_u (
		.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .hs_mode(hs_mode),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_data(rd_data), .gc_reset(gc_reset), .burst_en(burst_en),
		.latch_mode(latch_mode), .int_active(int_active), .flag_high(flag_high),
		.alert_clr(alert_clr)
	);
	i2c_ctrl_model bus_u (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_c(sda_c));
	// Fixed-address variant listens to the bus; its acks are only counted
	light_i2c_target #(.PIN_SELECT(1'b0), .TIMEOUT_CYCLES(200)) fix_u (
		.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl), .sda_in(sda_w),
		.sda_out(), .sda_oe_n(fix_oe_n), .addr_sel(addr_sel), .hs_mode(), .wr_valid(),
		.wr_addr(), .wr_data(), .rd_addr(), .rd_data(rd_data), .gc_reset(),
		.burst_en(burst_en), .latch_mode(latch_mode), .int_active(int_active),
		.flag_high(flag_high), .alert_clr()
	);

	// Compare and count
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic done(input string n);
		$display("test %s done", n);
	endtask
	// Start, address byte, ack expectation
	task automatic adr(input logic [7:0] b, input logic e);
		bus_u.start();
		bus_u.wb(b, a);
		chk("addr ack", 24'(e), 24'(a));
	endtask
	task automatic wbc(input logic [7:0] b);
		bus_u.wb(b, a);
		chk("byte ack", 24'(1), 24'(a));
	endtask
	task automatic rbc(input logic ak, input logic [7:0] e);
		bus_u.rb(ak, 8'h00, d);
		chk("read byte", 24'(e), 24'(d));
	endtask
	// Two-byte read ended by not-acknowledge
	task automatic rd2(input logic [15:0] e);
		adr(8'h89, 1'b1);
		rbc(1'b1, e[15:8]);
		rbc(1'b0, e[7:0]);
		bus_u.stop();
	endtask

	initial begin
		#1.8ms;
		failures++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (20) @(negedge clk_sys);
		// Each strap: own address acked, neighbour refused
		for (int s = 0; s < 4; s++) begin
			addr_sel = 2'(s);
			adr({tbl[s], 1'b0}, 1'b1);
			bus_u.stop();
			adr({tbl[s] ^ 7'h01, 1'b0}, 1'b0);
			bus_u.stop();
		end
		addr_sel = SEL_GND;
		chk("fixed acks", 24'(3), 24'(n_fx));
		done("address");
		adr(8'h88, 1'b1);
		wbc(8'h09);
		wbc(8'hA5);
		wbc(8'h3C);
		bus_u.stop();
		repeat (20) @(negedge clk_sys);
		chk("write", {8'h09, 16'hA53C}, w_seen);
		chk("write count", 24'(1), 24'(n_wr));
		done("write");
		rd2(16'h09F6);
		rd2(16'h09F6);
		done("read");
		burst_en = 1'b1;
		adr(8'h89, 1'b1);
		rbc(1'b1, 8'h09);
		rbc(1'b1, 8'hF6);
		rbc(1'b1, 8'h0A);
		rbc(1'b0, 8'hF5);
		bus_u.stop();
		rd2(16'h09F6);
		burst_en = 1'b0;
		done("burst");
		adr(8'h08, 1'b0);
		chk("hs on", 24'(1), 24'(hs_mode));
		adr(8'h88, 1'b1);
		chk("hs kept", 24'(1), 24'(hs_mode));
		bus_u.stop();
		repeat (20) @(negedge clk_sys);
		chk("hs off", 24'(0), 24'(hs_mode));
		done("high speed");
		adr(8'h00, 1'b1);
		wbc(8'h06);
		bus_u.stop();
		chk("gc count", 24'(1), 24'(n_gc));
		rd2(16'h00FF);
		done("general call");
		int_active = 1'b1;
		flag_high = 1'b1;
		adr(8'h19, 1'b0);
		bus_u.stop();
		latch_mode = 1'b1;
		adr(8'h19, 1'b1);
		rbc(1'b0, 8'h89);
		bus_u.stop();
		chk("alert won", 24'(1), 24'(n_al));
		adr(8'h19, 1'b1);
		bus_u.rb(1'b0, 8'h80, d);
		bus_u.stop();
		chk("lost bits", 24'(8'h7F), 24'(d));
		chk("alert lost", 24'(1), 24'(n_al));
		latch_mode = 1'b0;
		int_active = 1'b0;
		done("alert");
		adr(8'h89, 1'b1);
		repeat (40) @(negedge clk_sys);
		chk("drive before", 24'(0), 24'(sda_oe_n));
		repeat (300) @(negedge clk_sys);
		chk("timeout", 24'(1), 24'(sda_oe_n));
		bus_u.stop();
		rd2(16'h00FF);
		done("timeout");
		tally_and_finish();
	end
endmodule : light_i2c_target_bench
